//--- src/hart_trap_regs.svh
`ifndef HART_TRAP_REGS_SVH
`define HART_TRAP_REGS_SVH

// Privilege encodings
`define PRIV_U 2'h0
`define PRIV_S 2'h1
`define PRIV_M 2'h3
`define RST_PRIV `PRIV_M

// Interrupt cause IDs, also bit positions in the pending vector
`define IRQ_USI 0
`define IRQ_SSI 1
`define IRQ_MSI 3
`define IRQ_UTI 4
`define IRQ_STI 5
`define IRQ_MTI 7
`define IRQ_UEI 8
`define IRQ_SEI 9
`define IRQ_MEI 11
`define IRQ_LOCAL_BASE 16

// Exception causes
`define EXC_ILLEGAL 2
`define EXC_ECALL_U 8
`define EXC_ECALL_S 9
`define EXC_ECALL_M 11

// Status bit positions
`define ST_UIE 0
`define ST_SIE 1
`define ST_MIE 3
`define ST_UPIE 4
`define ST_SPIE 5
`define ST_MPIE 7
`define ST_SPP 8
`define ST_MPP 11

// Control register numbers
`define CSR_UEPC 12'h041
`define CSR_SSTATUS 12'h100
`define CSR_SIE 12'h104
`define CSR_SEPC 12'h141
`define CSR_SCAUSE 12'h142
`define CSR_SIP 12'h144
`define CSR_MSTATUS 12'h300
`define CSR_MEDELEG 12'h302
`define CSR_MIDELEG 12'h303
`define CSR_MIE 12'h304
`define CSR_MEPC 12'h341
`define CSR_MCAUSE 12'h342
`define CSR_MIP 12'h344

`endif

//--- src/hart_trap_pkg.sv
package hart_trap_pkg;

  typedef logic [1:0] priv_t;

  typedef struct packed {
    logic is_irq;
    logic [4:0] cause;
    priv_t target;
  } trap_info_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [11:0] addr;
  } csr_cmd_t;

endpackage

//--- src/hart_privilege_interrupt_trap.sv
// Overview of operation
// RL1: Machine mode always exists, reset into it.
// RL2: One, two or three privilege levels.
// RL3: User interrupts only with N extension.
// RL4: Software causes: supervisor 1, machine 3.
// RL5: Timer causes: supervisor 5, machine 7.
// RL6: External causes: supervisor 9, machine 11.
// RL7: Machine interrupts trap to machine unless delegated.
// RL8: Supervisor interrupts wait while in machine mode.
// RL9: Supervisor cannot reach machine interrupt configuration.
// RL10: Each level owns its registers or bits.
// RL11: Register zero reads zero; 31 hold state.
// RL12: ECALL cause names the current privilege.
// RL13: xRET legal at level x or above.
// RL14: Software saves context before switching levels.
// RL15: Vectored controller gives 3,7,11; locals from 16.
// RL16: Timer interrupter gives 3,7; router drives 11.
// RL17: Global router IDs independent of local causes.
// RL18: Interrupt entry clears machine global enable.
`timescale 1ns/1ps
`include "hart_trap_regs.svh"

module hart_privilege_interrupt_trap
  import hart_trap_pkg::*;
#(
  parameter int LEVELS = 3,
  parameter bit HAS_N = 1'b0,
  parameter bit VECTORED = 1'b0,
  parameter int NUM_LOCAL = 16,
  parameter int XLEN = 32
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sw_irq_m,
  input wire logic tmr_irq_m,
  input wire logic ext_irq_global,
  input wire logic ext_irq_local,
  input wire logic sw_irq_s,
  input wire logic tmr_irq_s,
  input wire logic ext_irq_s,
  input wire logic [2:0] usr_irq,
  input wire logic [NUM_LOCAL-1:0] local_irq,
  input wire logic trap_ready,
  input wire logic [XLEN-1:0] pc_in,
  input wire logic ecall,
  input wire logic mret,
  input wire logic sret,
  input wire logic uret,
  output logic irq_req,
  output logic trap_take,
  output trap_info_t trap_info,
  output logic ret_valid,
  output logic [XLEN-1:0] ret_pc,
  output priv_t priv_mode,
  input wire csr_cmd_t csr_cmd,
  input wire logic [XLEN-1:0] csr_wdata,
  output logic [XLEN-1:0] csr_rdata,
  output logic csr_fault,
  input wire logic rf_we,
  input wire logic [4:0] rf_waddr,
  input wire logic [XLEN-1:0] rf_wdata,
  input wire logic [4:0] rf_raddr_a,
  input wire logic [4:0] rf_raddr_b,
  output logic [XLEN-1:0] rf_rdata_a,
  output logic [XLEN-1:0] rf_rdata_b
);

  // Unsupported level counts fall back to machine only
  // RL2: level configuration
  localparam bit HAS_S = (LEVELS == 3);
  localparam bit HAS_U = (LEVELS == 2) || (LEVELS == 3);
  // RL3: user interrupts need N
  localparam bit HAS_NU = HAS_N && HAS_U;
  localparam priv_t LOWEST = HAS_U ? `PRIV_U : `PRIV_M;

  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] M_BITS = (ONE << `IRQ_MSI) | (ONE << `IRQ_MTI) | (ONE << `IRQ_MEI);
  localparam logic [31:0] S_BITS = HAS_S ?
    ((ONE << `IRQ_SSI) | (ONE << `IRQ_STI) | (ONE << `IRQ_SEI)) : 32'h0000_0000;
  localparam logic [31:0] U_BITS = HAS_NU ?
    ((ONE << `IRQ_USI) | (ONE << `IRQ_UTI) | (ONE << `IRQ_UEI)) : 32'h0000_0000;
  localparam logic [31:0] IMPL = M_BITS | S_BITS | U_BITS;
  localparam logic [31:0] DELEGABLE = HAS_S ? (IMPL & ~U_BITS) : 32'h0000_0000;
  localparam logic [31:0] EDELEG_W = HAS_S ?
    ((ONE << `EXC_ILLEGAL) | (ONE << `EXC_ECALL_U) | (ONE << `EXC_ECALL_S)) : 32'h0000_0000;
  localparam logic [31:0] SST_MASK = (ONE << `ST_SIE) | (ONE << `ST_SPIE) | (ONE << `ST_SPP)
    | (HAS_NU ? ((ONE << `ST_UIE) | (ONE << `ST_UPIE)) : 32'h0000_0000);

  // Highest set index wins; locals at 16 and up outrank the fixed causes
  function automatic logic [4:0] top_idx(input logic [31:0] v);
    top_idx = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        top_idx = 5'(i);
      end
    end
  endfunction

  function automatic priv_t legal_priv(input priv_t p);
    legal_priv = ((p == `PRIV_S) && HAS_S) || ((p == `PRIV_U) && HAS_U) ? p : `PRIV_M;
  endfunction

  // RL1: reset in machine mode
  priv_t priv_r;
  logic uie_r, sie_r, mie_r, upie_r, spie_r, mpie_r, spp_r;
  priv_t mpp_r;
  logic [31:0] mie_en_r, mideleg_r, medeleg_r;
  logic [XLEN-1:0] mepc_r, sepc_r, uepc_r;
  logic [5:0] mcause_r, scause_r;

  // Interrupt sources
  logic [31:0] local_vec;
  logic [31:0] local_impl;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_loc
      if (VECTORED && gi >= `IRQ_LOCAL_BASE && gi < `IRQ_LOCAL_BASE + NUM_LOCAL) begin : g_on
        // RL15: extra locals from 16
        assign local_vec[gi] = local_irq[gi - `IRQ_LOCAL_BASE];
        assign local_impl[gi] = 1'b1;
      end else begin : g_off
        assign local_vec[gi] = 1'b0;
        assign local_impl[gi] = 1'b0;
      end
    end
  endgenerate

  // RL16: router drives cause 11 when the timer interrupter is used
  // RL17: only the line reaches the hart, never the router's own IDs
  wire ext_m = VECTORED ? ext_irq_local : ext_irq_global;
  // RL4: software causes
  // RL5: timer causes
  // RL6: external causes
  wire [31:0] fixed_src = (32'(sw_irq_m) << `IRQ_MSI) | (32'(tmr_irq_m) << `IRQ_MTI)
    | (32'(ext_m) << `IRQ_MEI) | (32'(sw_irq_s) << `IRQ_SSI) | (32'(tmr_irq_s) << `IRQ_STI)
    | (32'(ext_irq_s) << `IRQ_SEI) | (32'(usr_irq[0]) << `IRQ_USI)
    | (32'(usr_irq[1]) << `IRQ_UTI) | (32'(usr_irq[2]) << `IRQ_UEI);
  // Lines that exist, not lines that happen to be high
  wire [31:0] impl_all = IMPL | local_impl;
  wire [31:0] pend = (fixed_src & IMPL) | local_vec;
  wire [31:0] armed = pend & mie_en_r;

  // RL7: undelegated go to machine
  wire m_ok = (priv_r != `PRIV_M) || mie_r;
  // RL8: supervisor causes never preempt machine mode
  // Undelegated supervisor lines wait for a lower mode
  wire [31:0] m_mask = (priv_r == `PRIV_M) ? ~S_BITS : 32'hFFFF_FFFF;
  wire [31:0] hit_m = armed & ~mideleg_r & ~U_BITS & m_mask & {32{m_ok}};
  // RL8: supervisor interrupts wait in machine mode
  wire s_ok = (priv_r == `PRIV_U) || ((priv_r == `PRIV_S) && sie_r);
  wire [31:0] hit_s = armed & mideleg_r & {32{s_ok}};
  // RL3: user mode only with N
  wire u_ok = HAS_NU && (priv_r == `PRIV_U) && uie_r;
  wire [31:0] hit_u = armed & U_BITS & {32{u_ok}};

  wire any_m = |hit_m;
  wire any_s = |hit_s;
  wire any_u = |hit_u;
  wire [4:0] irq_cause = any_m ? top_idx(hit_m) : any_s ? top_idx(hit_s) : top_idx(hit_u);
  wire priv_t irq_tgt = any_m ? `PRIV_M : any_s ? `PRIV_S : `PRIV_U;

  // RL13: return legality by level
  wire mret_ok = priv_r == `PRIV_M;
  wire sret_ok = HAS_S && (priv_r != `PRIV_U);
  wire uret_ok = HAS_NU;
  wire do_mret = mret && mret_ok;
  wire do_sret = sret && sret_ok;
  wire do_uret = uret && uret_ok;
  wire ret_bad = (mret && !mret_ok) || (sret && !sret_ok) || (uret && !uret_ok);

  // RL12: ecall cause from privilege
  wire [4:0] ecall_cause = (priv_r == `PRIV_M) ? 5'(`EXC_ECALL_M) :
    (priv_r == `PRIV_S) ? 5'(`EXC_ECALL_S) : 5'(`EXC_ECALL_U);
  wire [4:0] exc_cause = ecall ? ecall_cause : 5'(`EXC_ILLEGAL);
  wire exc_now = ecall || ret_bad;
  wire exc_deleg = medeleg_r[exc_cause] && (priv_r != `PRIV_M);

  // Exceptions are synchronous to the instruction; interrupts wait for a boundary
  wire irq_any = any_m || any_s || any_u;
  wire irq_take = irq_any && trap_ready && !exc_now && !do_mret && !do_sret && !do_uret;
  wire taken = exc_now || irq_take;
  wire priv_t tgt = exc_now ? (exc_deleg ? `PRIV_S : `PRIV_M) : irq_tgt;
  wire [4:0] cause = exc_now ? exc_cause : irq_cause;
  wire go_m = taken && (tgt == `PRIV_M);
  wire go_s = taken && (tgt == `PRIV_S);
  wire go_u = taken && (tgt == `PRIV_U);

  assign irq_req = irq_any;

  // Control register decode
  wire [11:0] ca = csr_cmd.addr;
  wire sel_uepc = HAS_NU && (ca == `CSR_UEPC);
  wire sel_sst = HAS_S && (ca == `CSR_SSTATUS);
  wire sel_sie = HAS_S && (ca == `CSR_SIE);
  wire sel_sepc = HAS_S && (ca == `CSR_SEPC);
  wire sel_scause = HAS_S && (ca == `CSR_SCAUSE);
  wire sel_sip = HAS_S && (ca == `CSR_SIP);
  wire sel_mst = ca == `CSR_MSTATUS;
  wire sel_medeleg = HAS_S && (ca == `CSR_MEDELEG);
  wire sel_mideleg = HAS_S && (ca == `CSR_MIDELEG);
  wire sel_mie = ca == `CSR_MIE;
  wire sel_mepc = ca == `CSR_MEPC;
  wire sel_mcause = ca == `CSR_MCAUSE;
  wire sel_mip = ca == `CSR_MIP;
  wire known = sel_uepc | sel_sst | sel_sie | sel_sepc | sel_scause | sel_sip | sel_mst
    | sel_medeleg | sel_mideleg | sel_mie | sel_mepc | sel_mcause | sel_mip;
  // RL9: lower levels are refused machine registers
  wire lvl_ok = priv_r >= ca[9:8];
  wire csr_ok = csr_cmd.req && known && lvl_ok;
  wire csr_wr = csr_ok && csr_cmd.we;
  wire [31:0] wd = csr_wdata[31:0];

  wire [31:0] mst_v = (32'(uie_r) << `ST_UIE) | (32'(sie_r) << `ST_SIE)
    | (32'(mie_r) << `ST_MIE) | (32'(upie_r) << `ST_UPIE) | (32'(spie_r) << `ST_SPIE)
    | (32'(mpie_r) << `ST_MPIE) | (32'(spp_r) << `ST_SPP) | (32'(mpp_r) << `ST_MPP);
  // RL10: supervisor sees only its own bits
  wire [31:0] sst_v = mst_v & SST_MASK;
  wire [31:0] sie_v = mie_en_r & mideleg_r;
  wire [31:0] sip_v = pend & mideleg_r;
  wire [XLEN-1:0] mcause_v = {mcause_r[5], {(XLEN-6){1'b0}}, mcause_r[4:0]};
  wire [XLEN-1:0] scause_v = {scause_r[5], {(XLEN-6){1'b0}}, scause_r[4:0]};
  wire [XLEN-1:0] rd_mux = ({XLEN{sel_uepc}} & uepc_r) | ({XLEN{sel_sepc}} & sepc_r)
    | ({XLEN{sel_mepc}} & mepc_r) | ({XLEN{sel_mcause}} & mcause_v)
    | ({XLEN{sel_scause}} & scause_v) | ({XLEN{sel_sst}} & XLEN'(sst_v))
    | ({XLEN{sel_sie}} & XLEN'(sie_v)) | ({XLEN{sel_sip}} & XLEN'(sip_v))
    | ({XLEN{sel_mst}} & XLEN'(mst_v)) | ({XLEN{sel_medeleg}} & XLEN'(medeleg_r))
    | ({XLEN{sel_mideleg}} & XLEN'(mideleg_r)) | ({XLEN{sel_mie}} & XLEN'(mie_en_r))
    | ({XLEN{sel_mip}} & XLEN'(pend));

  // Status next values; trap entry overrides a same-cycle write
  wire w_mst = csr_wr && sel_mst;
  wire w_sst = csr_wr && sel_sst;
  wire w_st = w_mst || w_sst;
  // RL18: machine enable cleared on entry
  wire mie_nxt = go_m ? 1'b0 : do_mret ? mpie_r : w_mst ? wd[`ST_MIE] : mie_r;
  wire mpie_nxt = go_m ? mie_r : do_mret ? 1'b1 : w_mst ? wd[`ST_MPIE] : mpie_r;
  wire priv_t mpp_nxt = go_m ? priv_r : do_mret ? LOWEST :
    w_mst ? legal_priv(wd[`ST_MPP +: 2]) : mpp_r;
  wire sie_nxt = HAS_S && (go_s ? 1'b0 : do_sret ? spie_r : w_st ? wd[`ST_SIE] : sie_r);
  wire spie_nxt = HAS_S && (go_s ? sie_r : do_sret ? 1'b1 : w_st ? wd[`ST_SPIE] : spie_r);
  wire spp_nxt = HAS_S && (go_s ? priv_r[0] : do_sret ? 1'b0 : w_st ? wd[`ST_SPP] : spp_r);
  wire uie_nxt = HAS_NU && (go_u ? 1'b0 : do_uret ? upie_r : w_st ? wd[`ST_UIE] : uie_r);
  wire upie_nxt = HAS_NU && (go_u ? uie_r : do_uret ? 1'b1 : w_st ? wd[`ST_UPIE] : upie_r);
  wire priv_t priv_nxt = go_m ? `PRIV_M : go_s ? `PRIV_S : go_u ? `PRIV_U :
    do_mret ? mpp_r : do_sret ? (spp_r ? `PRIV_S : `PRIV_U) : do_uret ? `PRIV_U : priv_r;

  wire [31:0] mie_en_nxt = (csr_wr && sel_mie) ? (wd & impl_all) :
    (csr_wr && sel_sie) ? ((mie_en_r & ~mideleg_r) | (wd & mideleg_r)) : mie_en_r;
  wire [XLEN-1:0] ret_pc_nxt = do_mret ? mepc_r : do_sret ? sepc_r : uepc_r;
  wire [5:0] cause_w = {irq_take, cause};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      priv_r <= `RST_PRIV;
      {uie_r, sie_r, mie_r, upie_r, spie_r, mpie_r, spp_r} <= 7'h00;
      mpp_r <= `RST_PRIV;
    end else begin
      priv_r <= priv_nxt;
      {uie_r, sie_r, mie_r} <= {uie_nxt, sie_nxt, mie_nxt};
      {upie_r, spie_r, mpie_r} <= {upie_nxt, spie_nxt, mpie_nxt};
      spp_r <= spp_nxt;
      mpp_r <= mpp_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mie_en_r <= 32'h0000_0000;
      mideleg_r <= 32'h0000_0000;
      medeleg_r <= 32'h0000_0000;
    end else begin
      mie_en_r <= mie_en_nxt;
      // RL7: delegation register
      if (csr_wr && sel_mideleg) begin
        // Locals delegable only when supervisor exists
        mideleg_r <= wd & (DELEGABLE | (HAS_S ? local_impl : 32'h0000_0000));
      end
      if (csr_wr && sel_medeleg) begin
        medeleg_r <= wd & EDELEG_W;
      end
    end
  end

  // Saved pc per level; saved cause for machine and supervisor only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mepc_r <= '0;
      sepc_r <= '0;
      uepc_r <= '0;
      mcause_r <= 6'h00;
      scause_r <= 6'h00;
    end else begin
      mepc_r <= go_m ? pc_in : (csr_wr && sel_mepc) ? csr_wdata : mepc_r;
      sepc_r <= go_s ? pc_in : (csr_wr && sel_sepc) ? csr_wdata : sepc_r;
      uepc_r <= go_u ? pc_in : (csr_wr && sel_uepc) ? csr_wdata : uepc_r;
      mcause_r <= go_m ? cause_w : mcause_r;
      scause_r <= go_s ? cause_w : scause_r;
    end
  end

  // Registered answers to the core
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trap_take <= 1'b0;
      trap_info <= '0;
      ret_valid <= 1'b0;
      ret_pc <= '0;
      csr_rdata <= '0;
      csr_fault <= 1'b0;
    end else begin
      trap_take <= taken;
      trap_info <= taken ? {irq_take, cause, tgt} : trap_info;
      // RL13: return to trap level pc
      ret_valid <= (do_mret || do_sret || do_uret) && !exc_now;
      ret_pc <= (do_mret || do_sret || do_uret) ? ret_pc_nxt : ret_pc;
      csr_rdata <= csr_ok ? rd_mux : '0;
      csr_fault <= csr_cmd.req && !csr_ok;
    end
  end

  assign priv_mode = priv_r;

  // RL11: only x1..x31 hold state
  logic [XLEN-1:0] rf_mem [31:1];
  always_ff @(posedge sys_clk) begin
    if (rf_we && (rf_waddr != 5'h00)) begin
      rf_mem[rf_waddr] <= rf_wdata;
    end
  end

  // RL11: register zero reads zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rf_rdata_a <= '0;
      rf_rdata_b <= '0;
    end else begin
      rf_rdata_a <= (rf_raddr_a == 5'h00) ? '0 : rf_mem[rf_raddr_a];
      rf_rdata_b <= (rf_raddr_b == 5'h00) ? '0 : rf_mem[rf_raddr_b];
    end
  end

endmodule

//--- test/hart_trap_props.sv
`timescale 1ns/1ps
`include "hart_trap_regs.svh"
module hart_trap_props
  import hart_trap_pkg::*;
#(
  parameter int XLEN = 32,
  parameter bit VECTORED = 1'b0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ecall,
  input wire logic mret,
  input wire logic sret,
  input wire logic uret,
  input wire logic trap_ready,
  input wire logic irq_req,
  input wire logic trap_take,
  input wire trap_info_t trap_info,
  input wire logic ret_valid,
  input wire priv_t priv_mode,
  input wire csr_cmd_t csr_cmd,
  input wire logic csr_fault,
  input wire logic [4:0] rf_raddr_a,
  input wire logic [XLEN-1:0] rf_rdata_a
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire any_op = ecall | mret | sret | uret;
  sequence s_irq_seen; irq_req && trap_ready && !any_op; endsequence
  sequence s_irq_entry; trap_take && trap_info.is_irq; endsequence
  property p_rst_priv; $fell(sys_rst) |-> priv_mode == `PRIV_M && !trap_take; endproperty
  property p_ecall;
    ecall |=> trap_take && !trap_info.is_irq && trap_info.cause ==
      ($past(priv_mode) == `PRIV_M ? 5'h0B : $past(priv_mode) == `PRIV_S ? 5'h09 : 5'h08);
  endproperty
  property p_irq; s_irq_seen |=> s_irq_entry; endproperty
  property p_hold; !trap_ready && !any_op |=> !trap_take; endproperty
  property p_target; trap_take |-> priv_mode == trap_info.target; endproperty
  property p_no_user; s_irq_entry |-> trap_info.target != `PRIV_U; endproperty
  property p_cause;
    s_irq_entry |-> trap_info.cause inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0B} ||
      (VECTORED && trap_info.cause >= 5'h10);
  endproperty
  property p_mret; mret && priv_mode == `PRIV_M |=> ret_valid && !trap_take; endproperty
  property p_bad_ret;
    (mret || sret) && priv_mode == `PRIV_U |=> trap_take && trap_info.cause == 5'h02 && !ret_valid;
  endproperty
  property p_csr;
    csr_cmd.req && priv_mode != `PRIV_M && csr_cmd.addr[9:8] == 2'h3 |=> csr_fault;
  endproperty
  property p_x0; rf_raddr_a == 5'h00 |=> rf_rdata_a == '0; endproperty
  a_rst_priv: assert property (p_rst_priv) else $error("not machine after reset");
  a_ecall: assert property (p_ecall) else $error("ecall cause wrong");
  a_irq: assert property (p_irq) else $error("interrupt not taken");
  a_hold: assert property (p_hold) else $error("interrupt taken while not ready");
  a_target: assert property (p_target) else $error("mode differs from target");
  a_no_user: assert property (p_no_user) else $error("interrupt into user");
  a_cause: assert property (p_cause) else $error("bad interrupt cause");
  a_mret: assert property (p_mret) else $error("legal return refused");
  a_bad_ret: assert property (p_bad_ret) else $error("illegal return accepted");
  a_csr: assert property (p_csr) else $error("machine register reached");
  a_x0: assert property (p_x0) else $error("register zero nonzero");
endmodule

bind hart_privilege_interrupt_trap hart_trap_props #(.XLEN(XLEN), .VECTORED(VECTORED)) u_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .ecall(ecall), .mret(mret), .sret(sret),
  .uret(uret), .trap_ready(trap_ready), .irq_req(irq_req), .trap_take(trap_take),
  .trap_info(trap_info), .ret_valid(ret_valid), .priv_mode(priv_mode), .csr_cmd(csr_cmd),
  .csr_fault(csr_fault), .rf_raddr_a(rf_raddr_a), .rf_rdata_a(rf_rdata_a)
);

//--- test/irq_partner.sv
`timescale 1ns/1ps
module irq_partner #(
  parameter int NUM_LOCAL = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [2:0] req,
  input wire logic [NUM_LOCAL-1:0] lreq,
  output logic sw_irq_m,
  output logic tmr_irq_m,
  output logic ext_irq_global,
  output logic [NUM_LOCAL-1:0] local_irq
);
  logic [2:0] route_r;
  assign ext_irq_global = route_r[2];
  // timer block: software and timer, plus the three-stage router path to ext_irq_global and the registered local lines
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sw_irq_m <= 1'b0;
      tmr_irq_m <= 1'b0;
      route_r <= 3'h0;
      local_irq <= '0;
    end else begin
      sw_irq_m <= req[0];
      tmr_irq_m <= req[1];
      route_r <= {route_r[1:0], req[2]};
      local_irq <= lreq;
    end
  end
endmodule

//--- test/hart_privilege_interrupt_trap_test.sv
`timescale 1ns/1ps
`include "hart_trap_regs.svh"
module hart_privilege_interrupt_trap_test;
  import hart_trap_pkg::*;
  logic sys_clk, sys_rst, sw_irq_s, tmr_irq_s, ext_irq_s, trap_ready, ecall, mret, sret, uret;
  logic rf_we;
  logic [2:0] usr_irq, req;
  logic [15:0] lreq;
  logic [31:0] pc_in, csr_wdata, rf_wdata, rd;
  logic [4:0] rf_waddr, rf_raddr_a, rf_raddr_b;
  csr_cmd_t csr_cmd;
  wire logic sw_irq_m, tmr_irq_m, ext_irq_global, irq_req, trap_take, ret_valid, csr_fault;
  wire logic v_take;
  wire logic [15:0] local_irq;
  wire trap_info_t trap_info, v_info;
  wire priv_t priv_mode;
  wire logic [31:0] ret_pc, csr_rdata, rf_rdata_a, rf_rdata_b;
  int fails, checks_done, cyc;

  hart_privilege_interrupt_trap #(.LEVELS(3), .HAS_N(1'b0), .VECTORED(1'b0)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sw_irq_m(sw_irq_m), .tmr_irq_m(tmr_irq_m),
    .ext_irq_global(ext_irq_global), .ext_irq_local(ext_irq_global), .sw_irq_s(sw_irq_s),
    .tmr_irq_s(tmr_irq_s), .ext_irq_s(ext_irq_s), .usr_irq(usr_irq), .local_irq(local_irq),
    .trap_ready(trap_ready), .pc_in(pc_in), .ecall(ecall), .mret(mret), .sret(sret),
    .uret(uret), .irq_req(irq_req), .trap_take(trap_take), .trap_info(trap_info),
    .ret_valid(ret_valid), .ret_pc(ret_pc), .priv_mode(priv_mode), .csr_cmd(csr_cmd),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .csr_fault(csr_fault), .rf_we(rf_we),
    .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .rf_raddr_a(rf_raddr_a),
    .rf_raddr_b(rf_raddr_b), .rf_rdata_a(rf_rdata_a), .rf_rdata_b(rf_rdata_b));
  hart_privilege_interrupt_trap #(.LEVELS(3), .HAS_N(1'b0), .VECTORED(1'b1)) uut_vec (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sw_irq_m(sw_irq_m), .tmr_irq_m(tmr_irq_m),
    .ext_irq_global(ext_irq_global), .ext_irq_local(ext_irq_global), .sw_irq_s(sw_irq_s),
    .tmr_irq_s(tmr_irq_s), .ext_irq_s(ext_irq_s), .usr_irq(usr_irq), .local_irq(local_irq),
    .trap_ready(trap_ready), .pc_in(pc_in), .ecall(ecall), .mret(mret), .sret(sret),
    .uret(uret), .irq_req(), .trap_take(v_take), .trap_info(v_info), .ret_valid(),
    .ret_pc(), .priv_mode(), .csr_cmd(csr_cmd), .csr_wdata(csr_wdata), .csr_rdata(),
    .csr_fault(), .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
    .rf_raddr_a(rf_raddr_a), .rf_raddr_b(rf_raddr_b), .rf_rdata_a(), .rf_rdata_b());
  irq_partner u_irq (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .lreq(lreq),
    .sw_irq_m(sw_irq_m), .tmr_irq_m(tmr_irq_m), .ext_irq_global(ext_irq_global),
    .local_irq(local_irq));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task report_and_stop;
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      report_and_stop;
    end
  end

  task tick;
    @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One-cycle instruction pulse: 1 ecall, 2 mret, 4 sret, 8 uret
  task op(input logic [3:0] k);
    tick;
    {uret, sret, mret, ecall} = k;
    tick;
    {uret, sret, mret, ecall} = 4'h0;
  endtask
  task take(input logic irq, input logic [4:0] c, input priv_t t);
    chk(trap_take, 1'b1);
    chk(trap_info, {irq, c, t});
    chk(priv_mode, t);
  endtask
  task wait_take;
    int n;
    n = 0;
    do begin
      tick;
      n++;
    end while (trap_take !== 1'b1 && n < 20);
  endtask
  task idle(input int n);
    repeat (n) begin
      tick;
      chk(trap_take, 1'b0);
    end
  endtask
  task csr(input logic w, input logic [11:0] a, input logic [31:0] d, input logic f);
    tick;
    csr_cmd = '{1'b1, w, a};
    csr_wdata = d;
    tick;
    csr_cmd.req = 1'b0;
    chk(csr_fault, f);
    rd = csr_rdata;
  endtask

  task t_regfile;
    rf_we = 1'b1;
    rf_waddr = 5'h00;
    rf_wdata = 32'hFFFF_FFFF;
    tick;
    rf_waddr = 5'h05;
    rf_wdata = 32'h1234_5678;
    tick;
    rf_we = 1'b0;
    rf_raddr_b = 5'h05;
    tick;
    chk(rf_rdata_a, 32'h0000_0000);
    chk(rf_rdata_b, 32'h1234_5678);
  endtask
  task t_modes;
    pc_in = 32'h0000_1000;
    op(4'h1); take(1'b0, 5'h0B, `PRIV_M);
    op(4'h2); chk(ret_pc, 32'h0000_1000);
    op(4'h2); chk(priv_mode, `PRIV_U);
    chk(rf_rdata_b, 32'h1234_5678);
    usr_irq = 3'h7;
    idle(6);
    usr_irq = 3'h0;
    op(4'h1); take(1'b0, 5'h08, `PRIV_M);
    op(4'h2);
    op(4'h4); take(1'b0, 5'h02, `PRIV_M);
  endtask
  // Software, timer, external in turn; causes 3, 7, 11
  task t_mach_irq;
    csr(1'b1, 12'h304, 32'h0000_0888, 1'b0);
    for (int k = 0; k < 3; k++) begin
      csr(1'b1, 12'h300, 32'h0000_0008, 1'b0);
      trap_ready = 1'b0;
      req[k] = 1'b1;
      idle(6);
      trap_ready = 1'b1;
      wait_take;
      take(1'b1, 5'h03 + 5'(4 * k), `PRIV_M);
      chk(v_info, {1'b1, 5'h03 + 5'(4 * k), `PRIV_M});
      csr(1'b0, 12'h300, 32'h0, 1'b0);
      chk(rd[3], 1'b0);
      req[k] = 1'b0;
      idle(6);
      op(4'h2);
    end
  endtask
  task t_super;
    csr(1'b1, 12'h303, 32'h0000_0020, 1'b0);
    csr(1'b1, 12'h304, 32'h0000_08A8, 1'b0);
    tmr_irq_s = 1'b1;
    idle(4);
    csr(1'b1, 12'h300, 32'h0000_0808, 1'b0);
    op(4'h2); chk(priv_mode, `PRIV_S);
    csr(1'b0, 12'h304, 32'h0, 1'b1);
    csr(1'b1, 12'h100, 32'h0000_0002, 1'b0);
    wait_take; take(1'b1, 5'h05, `PRIV_S);
    tmr_irq_s = 1'b0;
    req[1] = 1'b1;
    wait_take; take(1'b1, 5'h07, `PRIV_M);
    req[1] = 1'b0;
    idle(4);
    op(4'h2);
    op(4'h1); take(1'b0, 5'h09, `PRIV_M);
    op(4'h2);
    op(4'h4); chk(ret_valid, 1'b1);
    op(4'h8); take(1'b0, 5'h02, `PRIV_M);
  endtask
  // Local line 2 is cause 18, seen only by the vectored build
  task t_vector;
    csr(1'b1, 12'h304, 32'h0004_0000, 1'b0);
    csr(1'b1, 12'h300, 32'h0000_0008, 1'b0);
    lreq = 16'h0004;
    tick;
    tick;
    chk(v_take, 1'b1);
    chk(v_info, {1'b1, 5'h12, `PRIV_M});
    chk(trap_take, 1'b0);
    lreq = 16'h0000;
  endtask

  initial begin
    sys_rst = 1'b1;
    {uret, sret, mret, ecall} = 4'h0;
    {sw_irq_s, tmr_irq_s, ext_irq_s, rf_we} = 4'h0;
    trap_ready = 1'b1;
    usr_irq = 3'h0;
    req = 3'h0;
    lreq = 16'h0000;
    pc_in = 32'h0;
    csr_cmd = '0;
    csr_wdata = 32'h0;
    rf_wdata = 32'h0;
    {rf_waddr, rf_raddr_a, rf_raddr_b} = 15'h0;
    repeat (12) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    chk(priv_mode, `PRIV_M);
    t_regfile;
    t_modes;
    t_mach_irq;
    t_super;
    t_vector;
    report_and_stop;
  end
endmodule
